// [rtl/mpio_pkg.sv]
package mpio_pkg;

   // Register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [3:0] OFS_VALUE    = 4'h0;
   localparam logic [3:0] OFS_EDGE_ONE = 4'h1;
   localparam logic [3:0] OFS_EDGE_TWO = 4'h2;
   localparam logic [3:0] OFS_CHANGE   = 4'h3;
   localparam logic [3:0] OFS_CHAR_ONE = 4'h4;
   localparam logic [3:0] OFS_CHAR_TWO = 4'h5;
   localparam logic [3:0] OFS_COMMAND  = 4'h6;
   localparam logic [3:0] OFS_EOS      = 4'h7;
   localparam logic [3:0] OFS_CONTROL  = 4'h8;
   localparam logic [3:0] OFS_STATUS   = 4'h9;

   // Value register fields
   localparam int VAL_RTS = 0;
   localparam int VAL_DTR = 1;
   localparam int VAL_IN_LSB = 2;

   // Input index within the three-bit input groups
   localparam int IN_CTS = 0;
   localparam int IN_DSR = 1;
   localparam int IN_CD  = 2;
   localparam int IN_W   = 3;

   // Option register two fields
   localparam int OPT_LOCAL  = 0;
   localparam int OPT_REMOTE = 1;
   localparam int OPT_TXFLOW = 2;
   localparam int OPT_RXFLOW = 3;

   // Option register one: bits 1:0 give character length 5..8
   localparam int LEN_LSB = 0;

   // Command, control and status fields
   localparam int CMD_OPT_CHANGED = 0;
   localparam int CTL_REQ_EN      = 0;
   localparam int CTL_TEST_PASS   = 1;
   localparam int CTL_TEST_DONE   = 2;

   // Reset values
   localparam logic [7:0] RST_VALUE    = 8'h00;
   localparam logic [7:0] RST_CHAR_ONE = 8'h03;
   localparam logic [7:0] RST_CHAR_TWO = 8'h00;

   // Change scan timing
   localparam int SCAN_PERIOD_NS = 2000000;
   localparam int CLK_PERIOD_NS  = 4;
   localparam int SCAN_CYCLES    = SCAN_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SCAN_W         = 20;

   // Self-test walks one bit across the data path
   localparam int TEST_STEPS = 8;
   localparam logic [3:0] TEST_LAST = 4'h7;

   typedef enum logic [1:0]
   {
      MPIO_TEST  = 2'b00,
      MPIO_CHECK = 2'b01,
      MPIO_DONE  = 2'b11
   } mpio_test_t;

endpackage

// [rtl/mpio_channel.sv]
// Notes on behaviour
// (RL1) Four modem pins per channel, each a modem line or general-purpose I/O.
// (RL2) Send-request/clear pins serve transmitter; terminal/set-ready pins serve receiver.
// (RL3) Transmit flow on: block drives send-request itself, senses clear-to-send.
// (RL4) Clear-to-send checked when FIFO char moves into holding register.
// (RL5) Receive flow on: terminal-ready negated at FIFO threshold; host may re-assert.
// (RL6) Host drives outputs and reads inputs directly through the value register.
// (RL7) Select input chooses terminal-ready pin as output or carrier-detect input.
// (RL8) Inverted sense: written one drives pin low, low input reads one.
// (RL9) Each input's falling and rising detection enabled by two option registers.
// (RL10) Enabled edge sets change flag; with enable set, request output goes low.
// (RL11) Host clears change flags before writing end-of-service register.
// (RL12) Inputs sampled periodically and compared to stored sample, about 2 ms.
// (RL13) Inputs not latched; short pulses may be missed.
// (RL14) Local loop takes effect on option-changed command; transmit feeds receive.
// (RL15) During local loop the transmit pin rests at mark, logic one.
// (RL16) During local loop the modem pins keep working normally.
// (RL17) Remote loop echoes received characters back, none delivered to host.
// (RL18) Echoed characters are stripped and resent with option-one framing.
// (RL19) Remote loop transmitter keeps its own baud rate.
// (RL20) Remote loop bypasses FIFOs: receive holding goes to transmit holding.
// (RL21) Host should set transmit rate at or above receive rate in remote loop.
// (RL22) Basic self-test runs after every reset.
// (RL23) Modem inputs pass two flip-flops before sampling or comparison.
`timescale 1ns/100ps

module mpio_channel
#(
   parameter int SCAN_CYCLES = mpio_pkg::SCAN_CYCLES
)
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Register port
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData,
   // Modem pins, active low on the wire
   output logic            sendRequestPin_n,
   input  wire logic       clearToSendPin_n,
   input  wire logic       termReadyPinIn_n,
   output logic            termReadyPinOut_n,
   output logic            termReadyPinOe_n,
   input  wire logic       setReadyPin_n,
   input  wire logic       carrierPin_n,
   input  wire logic       terminal_ready_pin_select,
   output logic            modem_request_n,
   // Serial pins and bit engines
   output logic            txdPin,
   input  wire logic       rxdPin,
   input  wire logic       txdEngine,
   output logic            rxdEngine,
   // Transmit character path
   input  wire logic       txFifoValid,
   input  wire logic [7:0] txFifoData,
   output logic            txFifoPop,
   output logic            txHoldValid,
   output logic      [7:0] txHoldData,
   input  wire logic       txShiftTake,
   // Receive character path
   input  wire logic       rxHoldValid,
   input  wire logic [7:0] rxHoldData,
   output logic            rxHoldTake,
   output logic            rxFifoPush,
   output logic      [7:0] rxFifoData,
   input  wire logic       rxFifoReady,
   input  wire logic       rxFifoAtThreshold
);

   typedef struct packed {
      logic [2:0]              syncA;
      logic [2:0]              syncB;
      logic [2:0]              sample;
      logic [mpio_pkg::SCAN_W-1:0] scanCnt;
      logic [2:0]              fallEn;
      logic [2:0]              riseEn;
      logic [2:0]              change;
      logic                    sendReq;
      logic                    termReady;
      logic [7:0]              charOne;
      logic [7:0]              charTwo;
      logic [3:0]              activeTwo;
      logic                    reqEn;
      logic                    thrPrev;
      logic                    holdValid;
      logic [7:0]              holdData;
      logic [7:0]              rdData;
      mpio_pkg::mpio_test_t    testState;
      logic [3:0]              testCnt;
      logic [7:0]              testWalk;
      logic                    testPass;
   } mpio_state_t;

   mpio_state_t st_q;
   mpio_state_t st_d;

   // Mask a character to the length held in option register one
   function automatic logic [7:0] mpio_len_mask(input logic [7:0] ch, input logic [1:0] code);
      logic [7:0] m;
      m = 8'hFF >> (3'(2'h3 - code));
      return ch & m;
   endfunction

   // Pin level to register sense, and back
   function automatic logic mpio_sense(input logic pinLevel);
      return ~pinLevel; // RL8
   endfunction

   logic       localLoop;
   logic       remoteLoop;
   logic       txFlow;
   logic       rxFlow;
   logic [2:0] rawIn;
   logic [2:0] inNow;
   logic       ctsOn;
   logic       termIsOut;
   logic       scanTick;
   logic [2:0] fallSeen;
   logic [2:0] riseSeen;
   logic       holdLoad;
   logic       fifoLoad;
   logic       echoLoad;

   always_comb
   begin
      localLoop  = st_q.activeTwo[mpio_pkg::OPT_LOCAL];
      remoteLoop = st_q.charTwo[mpio_pkg::OPT_REMOTE];
      txFlow     = st_q.activeTwo[mpio_pkg::OPT_TXFLOW];
      rxFlow     = st_q.activeTwo[mpio_pkg::OPT_RXFLOW];
      termIsOut  = terminal_ready_pin_select; // RL7
      rawIn[mpio_pkg::IN_CTS] = clearToSendPin_n;
      rawIn[mpio_pkg::IN_DSR] = setReadyPin_n;
      rawIn[mpio_pkg::IN_CD]  = termIsOut ? carrierPin_n : termReadyPinIn_n; // RL7
      inNow[mpio_pkg::IN_CTS] = mpio_sense(st_q.syncB[mpio_pkg::IN_CTS]);
      inNow[mpio_pkg::IN_DSR] = mpio_sense(st_q.syncB[mpio_pkg::IN_DSR]);
      inNow[mpio_pkg::IN_CD]  = mpio_sense(st_q.syncB[mpio_pkg::IN_CD]);
      ctsOn    = inNow[mpio_pkg::IN_CTS];
      scanTick = (st_q.scanCnt == mpio_pkg::SCAN_W'(SCAN_CYCLES - 1));
      // Off-to-on and on-to-off against the stored sample
      riseSeen = scanTick ? (inNow & ~st_q.sample & st_q.riseEn) : 3'h0; // RL9 RL12
      fallSeen = scanTick ? (~inNow & st_q.sample & st_q.fallEn) : 3'h0; // RL9 RL12
      // The holding register only refills when empty or being emptied
      holdLoad = ~st_q.holdValid | txShiftTake;
      echoLoad = remoteLoop & rxHoldValid & holdLoad; // RL20 RL19
      // Clear-to-send is looked at now, not when the shifter loads
      fifoLoad = ~remoteLoop & txFifoValid & holdLoad & (~txFlow | ctsOn); // RL4 RL3
   end

   // Serial path
   always_comb
   begin
      txdPin    = localLoop ? 1'b1 : txdEngine; // RL15
      rxdEngine = localLoop ? txdEngine : rxdPin; // RL14
   end

   // Character handshakes
   always_comb
   begin
      txFifoPop   = fifoLoad;
      txHoldValid = st_q.holdValid;
      txHoldData  = st_q.holdData;
      rxFifoData  = rxHoldData;
      rxFifoPush  = rxHoldValid & ~remoteLoop; // RL17
      rxHoldTake  = remoteLoop ? echoLoad : (rxHoldValid & rxFifoReady); // RL20
   end

   always_comb
   begin
      st_d = st_q;
      // Two-stage input synchroniser; only syncB is ever looked at
      st_d.syncA = rawIn; // RL23
      st_d.syncB = st_q.syncA; // RL23
      // Periodic scan: a level that comes and goes between ticks is not seen
      st_d.scanCnt = scanTick ? '0 : st_q.scanCnt + mpio_pkg::SCAN_W'(1); // RL12 RL13
      if (scanTick)
      begin
         st_d.sample = inNow; // RL12
      end

      // Transmit holding register
      if (txShiftTake)
      begin
         st_d.holdValid = 1'b0;
      end
      if (fifoLoad)
      begin
         st_d.holdValid = 1'b1;
         st_d.holdData  = txFifoData;
      end
      if (echoLoad)
      begin
         st_d.holdValid = 1'b1;
         st_d.holdData  = mpio_len_mask(rxHoldData, st_q.charOne[mpio_pkg::LEN_LSB +: 2]); // RL18
      end

      // Automatic send-request follows pending transmit data
      if (txFlow)
      begin
         st_d.sendReq = txFifoValid | st_q.holdValid; // RL3 RL2
      end

      // Receive flow drops terminal-ready on reaching threshold
      st_d.thrPrev = rxFifoAtThreshold;
      if (rxFlow && rxFifoAtThreshold && !st_q.thrPrev)
      begin
         st_d.termReady = 1'b0; // RL5 RL2
      end

      // Register writes
      st_d.rdData = 8'h00;
      if (regWr)
      begin
         case (regAddr)
            mpio_pkg::OFS_VALUE:
            begin
               st_d.sendReq   = regWrData[mpio_pkg::VAL_RTS]; // RL6
               st_d.termReady = regWrData[mpio_pkg::VAL_DTR]; // RL6 RL5
            end
            mpio_pkg::OFS_EDGE_ONE: st_d.fallEn = regWrData[2:0]; // RL9
            mpio_pkg::OFS_EDGE_TWO: st_d.riseEn = regWrData[2:0]; // RL9
            mpio_pkg::OFS_CHANGE:   st_d.change = st_q.change & ~regWrData[2:0];
            mpio_pkg::OFS_CHAR_ONE: st_d.charOne = regWrData;
            mpio_pkg::OFS_CHAR_TWO: st_d.charTwo = regWrData;
            mpio_pkg::OFS_COMMAND:
            begin
               if (regWrData[mpio_pkg::CMD_OPT_CHANGED])
               begin
                  st_d.activeTwo = st_q.charTwo[3:0]; // RL14
               end
            end
            mpio_pkg::OFS_CONTROL:  st_d.reqEn = regWrData[mpio_pkg::CTL_REQ_EN];
            default:
            begin
               st_d.activeTwo = st_d.activeTwo;
            end
         endcase
      end
      // Hardware set wins over a clear in the same cycle
      st_d.change = st_d.change | riseSeen | fallSeen; // RL10

      // Register reads, data in the next cycle
      if (regRd)
      begin
         case (regAddr)
            mpio_pkg::OFS_VALUE:
            begin
               st_d.rdData[mpio_pkg::VAL_RTS] = st_q.sendReq;
               st_d.rdData[mpio_pkg::VAL_DTR] = st_q.termReady;
               st_d.rdData[mpio_pkg::VAL_IN_LSB +: 3] = inNow; // RL6 RL8
            end
            mpio_pkg::OFS_EDGE_ONE: st_d.rdData = {5'h00, st_q.fallEn};
            mpio_pkg::OFS_EDGE_TWO: st_d.rdData = {5'h00, st_q.riseEn};
            mpio_pkg::OFS_CHANGE:   st_d.rdData = {5'h00, st_q.change};
            mpio_pkg::OFS_CHAR_ONE: st_d.rdData = st_q.charOne;
            mpio_pkg::OFS_CHAR_TWO: st_d.rdData = st_q.charTwo;
            mpio_pkg::OFS_CONTROL:
            begin
               st_d.rdData[mpio_pkg::CTL_REQ_EN]    = st_q.reqEn;
               st_d.rdData[mpio_pkg::CTL_TEST_PASS] = st_q.testPass;
               st_d.rdData[mpio_pkg::CTL_TEST_DONE] = (st_q.testState == mpio_pkg::MPIO_DONE);
            end
            mpio_pkg::OFS_STATUS:   st_d.rdData = {4'h0, st_q.activeTwo};
            default:                st_d.rdData = 8'h00;
         endcase
      end

      // Self-test: walk a one through the sense inversion path twice
      case (st_q.testState)
         mpio_pkg::MPIO_TEST:
         begin
            st_d.testWalk  = 8'h01;
            st_d.testCnt   = 4'h0;
            st_d.testPass  = 1'b1;
            st_d.testState = mpio_pkg::MPIO_CHECK; // RL22
         end
         mpio_pkg::MPIO_CHECK:
         begin
            if (mpio_sense(mpio_sense(st_q.testWalk[st_q.testCnt[2:0]])) != 1'b1)
            begin
               st_d.testPass = 1'b0; // RL22
            end
            st_d.testWalk = {st_q.testWalk[6:0], st_q.testWalk[7]};
            st_d.testCnt  = st_q.testCnt + 4'h1;
            if (st_q.testCnt == mpio_pkg::TEST_LAST)
            begin
               st_d.testState = mpio_pkg::MPIO_DONE;
            end
         end
         mpio_pkg::MPIO_DONE:
         begin
            st_d.testState = mpio_pkg::MPIO_DONE;
         end
         default:
         begin
            st_d.testState = mpio_pkg::MPIO_TEST;
         end
      endcase
   end

   // Pin drive; the terminal-ready pin only drives when selected as output
   always_comb
   begin
      sendRequestPin_n  = ~st_q.sendReq; // RL8 RL1
      termReadyPinOut_n = ~st_q.termReady; // RL8 RL1
      termReadyPinOe_n  = ~termIsOut; // RL7 RL16
      modem_request_n   = ~(st_q.reqEn & (|st_q.change)); // RL10
      regRdData         = st_q.rdData;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         st_q           <= '0;
         st_q.syncA     <= 3'h7;
         st_q.syncB     <= 3'h7;
         st_q.sendReq   <= mpio_pkg::RST_VALUE[mpio_pkg::VAL_RTS];
         st_q.termReady <= mpio_pkg::RST_VALUE[mpio_pkg::VAL_DTR];
         st_q.charOne   <= mpio_pkg::RST_CHAR_ONE;
         st_q.charTwo   <= mpio_pkg::RST_CHAR_TWO;
         st_q.activeTwo <= mpio_pkg::RST_CHAR_TWO[3:0];
         st_q.testState <= mpio_pkg::MPIO_TEST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

endmodule // mpio_channel

// [dv/mpio_modem.sv]
`timescale 1ns/100ps

module mpio_modem
(
   // Clock
   input  wire logic       core_clk,
   // Device drive
   input  wire logic       sendRequestPin_n,
   input  wire logic       termReadyPinOut_n,
   input  wire logic       termReadyPinOe_n,
   // Bench control
   input  wire logic       autoClear,
   input  wire logic [2:0] lag,
   input  wire logic [2:0] lineOn,
   // Modem lines, low = on
   output logic            clearToSendPin_n,
   output logic            setReadyPin_n,
   output logic            carrierPin_n,
   output logic            termReadyWire_n
);
   logic [7:0] rtsHist_q = 8'h00;

   always_ff @(posedge core_clk)
      rtsHist_q <= {rtsHist_q[6:0], ~sendRequestPin_n};

   // Permission follows the request after a chosen lag, slow or prompt
   assign clearToSendPin_n = autoClear ? ~rtsHist_q[lag] : ~lineOn[0];
   assign setReadyPin_n    = ~lineOn[1];
   // Carrier moves to the shared pin when the device releases it; the idle pin lies
   assign carrierPin_n     = termReadyPinOe_n ? lineOn[2] : ~lineOn[2];
   assign termReadyWire_n  = termReadyPinOe_n ? ~lineOn[2] : termReadyPinOut_n;
endmodule // mpio_modem

// [dv/mpio_chk.sv]
`timescale 1ns/100ps

module mpio_chk
(
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       rst_n,
   // Pins
   input wire logic       regWr,
   input wire logic       termReadyPinOe_n,
   input wire logic       terminal_ready_pin_select,
   input wire logic       modem_request_n,
   input wire logic       txdPin,
   input wire logic       rxdPin,
   input wire logic       txdEngine,
   input wire logic       rxdEngine,
   // Character paths
   input wire logic       txFifoValid,
   input wire logic [7:0] txFifoData,
   input wire logic       txFifoPop,
   input wire logic       txHoldValid,
   input wire logic [7:0] txHoldData,
   input wire logic       txShiftTake,
   input wire logic [7:0] rxHoldData,
   input wire logic       rxHoldTake,
   input wire logic       rxFifoPush,
   input wire logic [7:0] rxFifoData,
   input wire logic       rxFifoReady
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   property p_loop_route;
      rxdEngine != rxdPin |-> rxdEngine == txdEngine && txdPin;
   endproperty
   a_loop_route: assert property (p_loop_route) else $error("loop feed wrong");
   property p_mark;
      txdPin != txdEngine |-> txdPin && rxdEngine == txdEngine;
   endproperty
   a_mark: assert property (p_mark) else $error("serial out not at mark");
   property p_pin_dir;
      termReadyPinOe_n == !terminal_ready_pin_select;
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong");
   property p_pop_free;
      txFifoPop |-> txFifoValid && (!txHoldValid || txShiftTake);
   endproperty
   a_pop_free: assert property (p_pop_free) else $error("pop into full holding");
   property p_pop_load;
      txFifoPop |=> txHoldValid && txHoldData == $past(txFifoData);
   endproperty
   a_pop_load: assert property (p_pop_load) else $error("holding not loaded");
   property p_echo;
      rxHoldTake && !rxFifoPush |=> txHoldValid;
   endproperty
   a_echo: assert property (p_echo) else $error("echo lost");
   property p_push;
      rxFifoPush |-> rxHoldTake == rxFifoReady && rxFifoData == rxHoldData;
   endproperty
   a_push: assert property (p_push) else $error("receive push wrong");
   property p_req_release;
      $rose(modem_request_n) |-> $past(regWr) || $past(regWr, 2);
   endproperty
   a_req_release: assert property (p_req_release) else $error("request dropped");
   c_loop: cover property (txdPin && !txdEngine);
   c_echo: cover property (rxHoldTake && !rxFifoPush);
   c_req: cover property ($fell(modem_request_n));
endmodule // mpio_chk

bind mpio_channel mpio_chk i_mpio_chk (.core_clk, .rst_n, .regWr, .termReadyPinOe_n,
   .terminal_ready_pin_select, .modem_request_n, .txdPin, .rxdPin, .txdEngine, .rxdEngine,
   .txFifoValid, .txFifoData, .txFifoPop, .txHoldValid, .txHoldData, .txShiftTake,
   .rxHoldData, .rxHoldTake, .rxFifoPush, .rxFifoData, .rxFifoReady);

// [dv/mpio_channel_tb.sv]
`timescale 1ns/100ps

module mpio_channel_tb;
`define CHK(v, e) begin checked++; if ((v) !== (e)) begin failures++; \
   $display("BAD %0t got %h want %h", $time, v, e); end end
   localparam int SCAN = 16;
   localparam int LIM  = 3 * SCAN + 8;
   logic       core_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00, txFifoData = 8'h00, rxHoldData = 8'h00;
   logic [7:0] regRdData, txHoldData, rxFifoData;
   logic       terminal_ready_pin_select = 1'b1, rxdPin = 1'b1, txdEngine = 1'b1;
   logic       txFifoValid = 1'b0, txShiftTake = 1'b0, rxHoldValid = 1'b0;
   logic       rxFifoReady = 1'b1, rxFifoAtThreshold = 1'b0, autoClear = 1'b0;
   logic       sendRequestPin_n, clearToSendPin_n, termReadyPinIn_n, termReadyPinOut_n;
   logic       termReadyPinOe_n, setReadyPin_n, carrierPin_n, modem_request_n, txdPin;
   logic       rxdEngine, txFifoPop, txHoldValid, rxHoldTake, rxFifoPush;
   logic [2:0] lag = 3'd4, lineOn = 3'b000;
   int         failures = 0, checked = 0;

   always #2 core_clk = ~core_clk;

   mpio_channel #(.SCAN_CYCLES(SCAN)) i_mpio_channel (.core_clk, .rst_n, .regAddr,
      .regWrData, .regWr, .regRd, .regRdData, .sendRequestPin_n, .clearToSendPin_n,
      .termReadyPinIn_n, .termReadyPinOut_n, .termReadyPinOe_n, .setReadyPin_n,
      .carrierPin_n, .terminal_ready_pin_select, .modem_request_n, .txdPin, .rxdPin,
      .txdEngine, .rxdEngine, .txFifoValid, .txFifoData, .txFifoPop, .txHoldValid,
      .txHoldData, .txShiftTake, .rxHoldValid, .rxHoldData, .rxHoldTake, .rxFifoPush,
      .rxFifoData, .rxFifoReady, .rxFifoAtThreshold);
   mpio_modem i_mpio_modem (.core_clk, .sendRequestPin_n, .termReadyPinOut_n,
      .termReadyPinOe_n, .autoClear, .lag, .lineOn, .clearToSendPin_n, .setReadyPin_n,
      .carrierPin_n, .termReadyWire_n(termReadyPinIn_n));

   task automatic end_of_test;
      if (failures == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 `CHK(regRdData, e)
   endtask

   task automatic wait_sig(ref logic s, input logic e);
      int n;
      n = 0;
      while (s !== e && n < LIM)
      begin
         @(posedge core_clk);
         #1 n++;
      end
      if (s !== e)
      begin
         failures++;
         $display("BAD %0t wait ran out", $time);
         end_of_test();
      end
   endtask

   initial
   begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      #1 `CHK({sendRequestPin_n, termReadyPinOut_n, modem_request_n}, 3'b111)
      repeat (12) @(posedge core_clk);
      rd(mpio_pkg::OFS_CONTROL, 8'h06);
      rd(mpio_pkg::OFS_CHAR_ONE, 8'h03);
      rd(4'hF, 8'h00);
      wr(mpio_pkg::OFS_VALUE, 8'h03);
      #1 `CHK({termReadyPinOut_n, sendRequestPin_n}, 2'b00)
      lineOn <= 3'b101;
      repeat (3) @(posedge core_clk);
      rd(mpio_pkg::OFS_VALUE, 8'h17);
      terminal_ready_pin_select <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd(mpio_pkg::OFS_VALUE, 8'h17);
      terminal_ready_pin_select <= 1'b1;
      wr(mpio_pkg::OFS_VALUE, 8'h00);
      lineOn <= 3'b000;
      wr(mpio_pkg::OFS_CONTROL, 8'h01);
      // A scan tick must store the idle lines, or the first rise is lost
      repeat (SCAN) @(posedge core_clk);
      // First pass turns each line on, second turns it off
      for (int e = 0; e < 2; e++)
         for (int i = 0; i < 3; i++)
         begin
            wr(mpio_pkg::OFS_EDGE_TWO, e ? 8'h00 : 8'h07);
            wr(mpio_pkg::OFS_EDGE_ONE, e ? 8'h07 : 8'h00);
            lineOn[i] <= ~lineOn[i];
            wait_sig(modem_request_n, 1'b0);
            rd(mpio_pkg::OFS_CHANGE, 8'(1 << i));
            wr(mpio_pkg::OFS_CHANGE, 8'(1 << i));
            wr(mpio_pkg::OFS_EOS, 8'h00);
            #1 `CHK(modem_request_n, 1'b1)
         end
      lineOn[0] <= 1'b1;
      repeat (LIM) @(posedge core_clk);
      rd(mpio_pkg::OFS_CHANGE, 8'h00);
      wr(mpio_pkg::OFS_CONTROL, 8'h00);
      lineOn[0] <= 1'b0;
      repeat (LIM) @(posedge core_clk);
      #1 `CHK(modem_request_n, 1'b1)
      rd(mpio_pkg::OFS_CHANGE, 8'h01);
      wr(mpio_pkg::OFS_CHANGE, 8'h01);
      txdEngine <= 1'b0;
      wr(mpio_pkg::OFS_CHAR_TWO, 8'h01);
      #1 `CHK(txdPin, 1'b0)
      wr(mpio_pkg::OFS_COMMAND, 8'h01);
      repeat (2) @(posedge core_clk);
      #1 `CHK({txdPin, rxdEngine}, 2'b10)
      wr(mpio_pkg::OFS_VALUE, 8'h01);
      #1 `CHK(sendRequestPin_n, 1'b0)
      rd(mpio_pkg::OFS_STATUS, 8'h01);
      wr(mpio_pkg::OFS_CHAR_TWO, 8'h04);
      wr(mpio_pkg::OFS_COMMAND, 8'h01);
      wr(mpio_pkg::OFS_VALUE, 8'h00);
      #1 `CHK({txdPin, rxdEngine}, 2'b01)
      autoClear   <= 1'b1;
      txFifoData  <= 8'hA5;
      txFifoValid <= 1'b1;
      @(posedge core_clk);
      #1 `CHK(txFifoPop, 1'b0)
      wait_sig(txFifoPop, 1'b1);
      @(posedge core_clk);
      txFifoValid <= 1'b0;
      autoClear   <= 1'b0;
      #1 `CHK({sendRequestPin_n, txHoldValid, txHoldData}, 10'h1A5)
      @(posedge core_clk);
      txShiftTake <= 1'b1;
      @(posedge core_clk);
      txShiftTake <= 1'b0;
      #1 `CHK(txHoldValid, 1'b0)
      repeat (2) @(posedge core_clk);
      txFifoValid <= 1'b1;
      repeat (4) @(posedge core_clk) #1 `CHK(txFifoPop, 1'b0)
      rxHoldData  <= 8'hFF;
      rxHoldValid <= 1'b1;
      #1 `CHK({rxFifoPush, rxHoldTake, rxFifoData}, 10'h3FF)
      @(posedge core_clk);
      rxHoldValid <= 1'b0;
      wr(mpio_pkg::OFS_CHAR_TWO, 8'h02);
      for (int n = 0; n < 4; n++)
      begin
         wr(mpio_pkg::OFS_CHAR_ONE, 8'(n));
         rxHoldValid <= 1'b1;
         #1 `CHK({rxFifoPush, rxHoldTake, txFifoPop}, 3'b010)
         @(posedge core_clk);
         rxHoldValid <= 1'b0;
         txShiftTake <= 1'b1;
         #1 `CHK({txHoldValid, txHoldData}, {1'b1, 8'hFF >> (3 - n)})
         @(posedge core_clk);
         txShiftTake <= 1'b0;
      end
      txFifoValid <= 1'b0;
      wr(mpio_pkg::OFS_CHAR_TWO, 8'h08);
      wr(mpio_pkg::OFS_COMMAND, 8'h01);
      wr(mpio_pkg::OFS_VALUE, 8'h02);
      rxFifoAtThreshold <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 `CHK(termReadyPinOut_n, 1'b1)
      wr(mpio_pkg::OFS_VALUE, 8'h02);
      #1 `CHK(termReadyPinOut_n, 1'b0)
      end_of_test();
   end
endmodule // mpio_channel_tb
